// ### verilog/boot_elect_consts.svh
// Overview of operation
// - election only after power-up or hard reset
// - soft init: flag picks firmware or wait
// - unique identifier, 32 or 8 bits, stored
// - arbitration priority derived from identifier
// - self-test first, then selection
// - new variant: quiet request line, issue nop
// - nop winner sets flag, fetches reset vector
// - nop losers clear flag, wait startup
// - old variant: first own select wins
// - final select: only flagged processor fetches
// - startup vector placed in address bits 19:12
// - halted: only init, nmi, smi, snoop, clock-stop
// - controller enable bit 8, zero at reset
// - mapped mode identifier in top byte
// - flag set only in elected boot processor
`ifndef BOOT_ELECT_CONSTS_SVH
`define BOOT_ELECT_CONSTS_SVH

// firmware entry after election
`define RESET_VECTOR      32'hFFFF_FFF0
// startup page vector position
`define STARTUP_VEC_LSB   12
// narrow identifier width without extended enumeration
`define ID_NARROW_W       8
// identifier byte position in mapped mode
`define MMIO_ID_LSB       24
// controller enable field in the spurious vector register
`define CTRL_ENABLE_BIT   8
// spurious vector register reset value
`define SVR_RESET         32'h0000_0000
// cycles without a request-line edge that count as quiet
`define BNR_QUIET_CYCLES  6'h10

`endif

// ### verilog/boot_elect_pkg.sv
package boot_elect_pkg;

  // controller state of one logical processor
  typedef enum logic [3:0] {
    ST_RESET      = 4'h0,
    ST_SELFTEST   = 4'h1,
    ST_WATCH_BNR  = 4'h2,
    ST_ARB_NOP    = 4'h3,
    ST_SEND_SEL   = 4'h4,
    ST_WAIT_SEL   = 4'h5,
    ST_SEND_FIN   = 4'h6,
    ST_WAIT_FIN   = 4'h7,
    ST_RUN_BOOT   = 4'h8,
    ST_WAIT_START = 4'h9,
    ST_RUN_SEC    = 4'hA,
    ST_HALTED     = 4'hB
  } elect_state_t;

  // message kinds on the inter-processor message path
  typedef enum logic [1:0] {
    MSG_BOOT_SELECT  = 2'h0,
    MSG_FINAL_SELECT = 2'h1,
    MSG_STARTUP      = 2'h2,
    MSG_SOFT_INIT    = 2'h3
  } msg_kind_t;

  // one message, broadcast or received
  typedef struct packed {
    logic        valid;
    msg_kind_t   kind;
    logic [31:0] src_id;
    logic [7:0]  vector;
  } ipi_msg_t;

  // firmware fetch request toward the core
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } fetch_req_t;

endpackage : boot_elect_pkg

// ### verilog/controller_regs.sv
`include "boot_elect_consts.svh"

module controller_regs (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  // identifier load
  input  wire logic        id_load_i,
  input  wire logic        id_wide_i,
  input  wire logic [31:0] id_value_i,
  // spurious vector register write
  input  wire logic        svr_wr_i,
  input  wire logic [31:0] svr_wdata_i,
  // stored values
  output logic      [31:0] id_q_o,
  output logic      [31:0] svr_q_o
);

  // identifier register, narrowed when enumeration is narrow
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      id_q_o <= 32'h0000_0000;
    else if (id_load_i)
      id_q_o <= id_wide_i ? id_value_i
                          : {24'h00_0000, id_value_i[`ID_NARROW_W-1:0]};
  end

  // spurious vector register, enable bit clear at reset
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      svr_q_o <= `SVR_RESET;
    else if (svr_wr_i)
      svr_q_o <= svr_wdata_i;
  end

endmodule : controller_regs

// ### verilog/boot_election.sv
`include "boot_elect_consts.svh"

module boot_election (
  // clock and hard reset
  input  wire logic                  mclk_i,
  input  wire logic                  rst_i,
  // topology strap and mode
  input  wire logic [31:0]           topo_id_i,
  input  wire logic                  ext_topology_i,
  input  wire logic                  new_variant_i,
  // self-test
  output logic                       built_in_self_test_start_o,
  input  wire logic                  built_in_self_test_done_i,
  // system bus election
  input  wire logic                  block_next_request_line_i,
  output logic                       nop_req_o,
  output logic [31:0]                arb_priority_o,
  input  wire logic                  nop_won_i,
  input  wire logic                  nop_lost_i,
  // message path
  output boot_elect_pkg::ipi_msg_t   msg_tx_o,
  input  wire logic                  msg_tx_ready_i,
  input  wire boot_elect_pkg::ipi_msg_t msg_rx_i,
  // core side
  output boot_elect_pkg::fetch_req_t fetch_o,
  input  wire logic                  core_halt_i,
  // interrupt and bus event requests
  input  wire logic                  intr_i,
  input  wire logic                  nmi_i,
  input  wire logic                  system_management_interrupt_i,
  input  wire logic                  snoop_i,
  input  wire logic                  clock_stop_request_i,
  output logic                       intr_take_o,
  output logic                       nmi_take_o,
  output logic                       smi_take_o,
  output logic                       snoop_take_o,
  output logic                       clock_stop_take_o,
  // spurious vector register access
  input  wire logic                  svr_wr_i,
  input  wire logic [31:0]           svr_wdata_i,
  // status
  output logic                       boot_processor_o,
  output logic                       elect_done_o,
  output logic                       ctrl_enable_o,
  output logic [31:0]                processor_identifier_o,
  output logic [31:0]                mmio_identifier_o,
  output boot_elect_pkg::elect_state_t state_o
);

  boot_elect_pkg::elect_state_t state_q;      // controller state
  boot_elect_pkg::elect_state_t state_d;      // next state
  logic                         flag_q;       // boot-processor flag
  logic                         done_q;       // election finished
  logic                         bnr_prev_q;   // request line last cycle
  logic [5:0]                   quiet_q;      // cycles without an edge
  logic [31:0]                  id_q;         // stored identifier
  logic [31:0]                  svr_q;        // spurious vector register
  logic                         rx_sel;       // boot select arriving
  logic                         rx_fin;       // final select arriving
  logic                         rx_start;     // startup message arriving
  logic                         soft_init;    // soft init arriving
  logic                         bnr_quiet;    // request line settled

  // startup address from an 8-bit page vector
  function automatic logic [31:0] startup_addr(input logic [7:0] vec);
    startup_addr = {12'h000, vec, 12'h000};
  endfunction : startup_addr

  // priority follows the identifier, unique as it is
  function automatic logic [31:0] prio_of(input logic [31:0] id);
    prio_of = id;
  endfunction : prio_of

  // decode of the received message
  assign rx_sel    = msg_rx_i.valid && (msg_rx_i.kind == boot_elect_pkg::MSG_BOOT_SELECT);
  assign rx_fin    = msg_rx_i.valid && (msg_rx_i.kind == boot_elect_pkg::MSG_FINAL_SELECT);
  assign rx_start  = msg_rx_i.valid && (msg_rx_i.kind == boot_elect_pkg::MSG_STARTUP);
  assign soft_init = msg_rx_i.valid && (msg_rx_i.kind == boot_elect_pkg::MSG_SOFT_INIT);
  assign bnr_quiet = (quiet_q == `BNR_QUIET_CYCLES);

  // identifier and enable register store
  controller_regs u_regs (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .id_load_i   (state_q == boot_elect_pkg::ST_RESET),
    .id_wide_i   (ext_topology_i),
    .id_value_i  (topo_id_i),
    .svr_wr_i    (svr_wr_i),
    .svr_wdata_i (svr_wdata_i),
    .id_q_o      (id_q),
    .svr_q_o     (svr_q)
  );

  // next state
  always_comb
  begin
    state_d = state_q;
    if (soft_init && done_q)
    begin
      // no new election after it completed
      state_d = flag_q ? boot_elect_pkg::ST_RUN_BOOT
                       : boot_elect_pkg::ST_WAIT_START;
    end
    else
    begin
      unique case (state_q)
        boot_elect_pkg::ST_RESET:
          state_d = boot_elect_pkg::ST_SELFTEST;
        boot_elect_pkg::ST_SELFTEST:
          // selection waits for the self-test
          if (built_in_self_test_done_i)
            state_d = new_variant_i ? boot_elect_pkg::ST_WATCH_BNR
                                    : boot_elect_pkg::ST_SEND_SEL;
        boot_elect_pkg::ST_WATCH_BNR:
          if (bnr_quiet)
            state_d = boot_elect_pkg::ST_ARB_NOP;
        boot_elect_pkg::ST_ARB_NOP:
          if (nop_won_i)
            state_d = boot_elect_pkg::ST_RUN_BOOT;
          else if (nop_lost_i)
            state_d = boot_elect_pkg::ST_WAIT_START;
        boot_elect_pkg::ST_SEND_SEL:
          // a select seen first decides: own source wins, any other processor's source loses
          if (rx_sel)
            state_d = (msg_rx_i.src_id == id_q) ? boot_elect_pkg::ST_SEND_FIN
                                                : boot_elect_pkg::ST_WAIT_START;
          else if (msg_tx_ready_i)
            state_d = boot_elect_pkg::ST_WAIT_SEL;
        boot_elect_pkg::ST_WAIT_SEL:
          if (rx_sel)
            state_d = (msg_rx_i.src_id == id_q) ? boot_elect_pkg::ST_SEND_FIN
                                                : boot_elect_pkg::ST_WAIT_START;
        boot_elect_pkg::ST_SEND_FIN:
          if (msg_tx_ready_i)
            state_d = boot_elect_pkg::ST_WAIT_FIN;
        boot_elect_pkg::ST_WAIT_FIN:
          // only the flagged processor answers the final select
          if (rx_fin && flag_q)
            state_d = boot_elect_pkg::ST_RUN_BOOT;
        boot_elect_pkg::ST_RUN_BOOT:
          state_d = boot_elect_pkg::ST_RUN_BOOT;
        boot_elect_pkg::ST_WAIT_START:
          // everything but a startup message is ignored
          if (rx_start)
            state_d = boot_elect_pkg::ST_RUN_SEC;
        boot_elect_pkg::ST_RUN_SEC:
          if (core_halt_i)
            state_d = boot_elect_pkg::ST_HALTED;
        boot_elect_pkg::ST_HALTED:
          state_d = boot_elect_pkg::ST_HALTED;
        default:
          state_d = boot_elect_pkg::ST_RESET;
      endcase
    end
  end

  // state register
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      state_q <= boot_elect_pkg::ST_RESET;
    else
      state_q <= state_d;
  end

  // boot-processor flag, set only on a win
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      flag_q <= 1'b0;
    else if (state_q == boot_elect_pkg::ST_ARB_NOP && nop_won_i)
      flag_q <= 1'b1;
    else if ((state_q == boot_elect_pkg::ST_SEND_SEL || state_q == boot_elect_pkg::ST_WAIT_SEL)
             && rx_sel && (msg_rx_i.src_id == id_q))
      flag_q <= 1'b1;
  end

  // election-finished marker, held until hard reset
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      done_q <= 1'b0;
    else if (state_d == boot_elect_pkg::ST_RUN_BOOT || state_d == boot_elect_pkg::ST_WAIT_START)
      done_q <= 1'b1;
  end

  // request-line quiet detector
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      bnr_prev_q <= 1'b0;
      quiet_q    <= 6'h00;
    end
    else
    begin
      bnr_prev_q <= block_next_request_line_i;
      if (state_q != boot_elect_pkg::ST_WATCH_BNR)
        quiet_q <= 6'h00;
      else if (block_next_request_line_i != bnr_prev_q)
        quiet_q <= 6'h00;
      else if (!bnr_quiet)
        quiet_q <= quiet_q + 6'h01;
    end
  end

  // firmware fetch request, one cycle on entry to a run state
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      fetch_o <= '0;
    else if (state_d == boot_elect_pkg::ST_RUN_BOOT && (state_q != state_d || soft_init))
      fetch_o <= '{valid: 1'b1, addr: `RESET_VECTOR};
    else if (state_q == boot_elect_pkg::ST_WAIT_START && rx_start && !soft_init)
      fetch_o <= '{valid: 1'b1, addr: startup_addr(msg_rx_i.vector)};
    else
      fetch_o <= '{valid: 1'b0, addr: fetch_o.addr};
  end

  // self-test start pulse
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      built_in_self_test_start_o <= 1'b0;
    else
      built_in_self_test_start_o <= (state_q == boot_elect_pkg::ST_RESET);
  end

  // outgoing select messages, held until taken
  always_comb
  begin
    msg_tx_o        = '0;
    msg_tx_o.src_id = id_q;
    if (state_q == boot_elect_pkg::ST_SEND_SEL)
    begin
      msg_tx_o.valid = 1'b1;
      msg_tx_o.kind  = boot_elect_pkg::MSG_BOOT_SELECT;
    end
    else if (state_q == boot_elect_pkg::ST_SEND_FIN)
    begin
      msg_tx_o.valid = 1'b1;
      msg_tx_o.kind  = boot_elect_pkg::MSG_FINAL_SELECT;
    end
  end

  // bus election request and priority
  assign nop_req_o      = (state_q == boot_elect_pkg::ST_ARB_NOP);
  assign arb_priority_o = prio_of(id_q);

  // event acceptance; halted takes only init, nmi, smi, snoop, clock-stop
  assign intr_take_o = intr_i && (state_q == boot_elect_pkg::ST_RUN_BOOT ||
                                  state_q == boot_elect_pkg::ST_RUN_SEC);
  assign nmi_take_o  = nmi_i && (state_q == boot_elect_pkg::ST_RUN_BOOT ||
                                 state_q == boot_elect_pkg::ST_RUN_SEC ||
                                 state_q == boot_elect_pkg::ST_HALTED);
  assign smi_take_o  = system_management_interrupt_i &&
                       (state_q == boot_elect_pkg::ST_RUN_BOOT ||
                        state_q == boot_elect_pkg::ST_RUN_SEC ||
                        state_q == boot_elect_pkg::ST_HALTED);
  assign snoop_take_o      = snoop_i;
  assign clock_stop_take_o = clock_stop_request_i;

  // status views
  assign boot_processor_o       = flag_q;
  assign elect_done_o           = done_q;
  assign ctrl_enable_o          = svr_q[`CTRL_ENABLE_BIT];
  assign processor_identifier_o = id_q;
  assign mmio_identifier_o      = {id_q[7:0], 24'h00_0000};
  assign state_o                = state_q;

endmodule : boot_election

// ### tb/boot_election_assertions.sv
`include "boot_elect_consts.svh"

module boot_election_assertions (
  // clock and reset
  input wire logic                         mclk_i,
  input wire logic                         rst_i,
  // causes
  input wire logic                         block_next_request_line_i,
  input wire logic                         nop_won_i,
  input wire logic                         nop_lost_i,
  input wire boot_elect_pkg::ipi_msg_t     msg_rx_i,
  input wire logic                         svr_wr_i,
  input wire logic [31:0]                  svr_wdata_i,
  // effects
  input wire logic                         built_in_self_test_start_o,
  input wire logic                         nop_req_o,
  input wire boot_elect_pkg::fetch_req_t   fetch_o,
  input wire logic                         boot_processor_o,
  input wire logic                         elect_done_o,
  input wire logic                         ctrl_enable_o,
  input wire logic [31:0]                  processor_identifier_o,
  input wire boot_elect_pkg::elect_state_t state_o
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  // received message decode and waiting state
  wire logic rx_start = msg_rx_i.valid && msg_rx_i.kind == boot_elect_pkg::MSG_STARTUP;
  wire logic rx_sel   = msg_rx_i.valid && msg_rx_i.kind == boot_elect_pkg::MSG_BOOT_SELECT;
  wire logic rx_init  = msg_rx_i.valid && msg_rx_i.kind == boot_elect_pkg::MSG_SOFT_INIT;
  wire logic waiting  = state_o == boot_elect_pkg::ST_WAIT_START;

  // one-cycle self-test kick
  sequence s_kick;
    built_in_self_test_start_o ##1 !built_in_self_test_start_o;
  endsequence : s_kick
  // reset-vector fetch as boot processor
  sequence s_boot_fetch;
    boot_processor_o && fetch_o.valid && fetch_o.addr == `RESET_VECTOR;
  endsequence : s_boot_fetch

  chk_kick_once: assert property ($fell(rst_i) |=> s_kick)
    else $error("self-test kick is not one pulse after reset");
  chk_quiet_wait: assert property (
    state_o == boot_elect_pkg::ST_WATCH_BNR && $changed(block_next_request_line_i)
    |=> !nop_req_o [*8]) else $error("nop request while line still toggles");
  chk_nop_win: assert property (nop_req_o && nop_won_i |=> s_boot_fetch)
    else $error("nop winner did not fetch the reset vector");
  chk_nop_lose: assert property (
    nop_req_o && nop_lost_i && !nop_won_i |=> !boot_processor_o && !fetch_o.valid && waiting)
    else $error("nop loser not waiting with clear flag");
  chk_own_select: assert property (
    (state_o == boot_elect_pkg::ST_SEND_SEL || state_o == boot_elect_pkg::ST_WAIT_SEL)
    && rx_sel |=> boot_processor_o == ($past(msg_rx_i.src_id) == $past(processor_identifier_o)))
    else $error("boot flag does not follow first select source");
  chk_start_page: assert property (
    waiting && rx_start |=> fetch_o.valid
    && fetch_o.addr == {12'h000, $past(msg_rx_i.vector), 12'h000})
    else $error("startup fetch address wrong");
  chk_wait_hold: assert property (waiting && !rx_start |=> waiting)
    else $error("waiting secondary left without startup");
  chk_soft_init: assert property (
    elect_done_o && rx_init |=> state_o == ($past(boot_processor_o) ?
    boot_elect_pkg::ST_RUN_BOOT : boot_elect_pkg::ST_WAIT_START))
    else $error("soft init did not follow the boot flag");
  chk_svr_enable: assert property (
    svr_wr_i |=> ctrl_enable_o == $past(svr_wdata_i[`CTRL_ENABLE_BIT]))
    else $error("controller enable does not follow bit 8");
endmodule : boot_election_assertions

bind boot_election boot_election_assertions i_chk (.*);

// ### tb/peer_bus_model.sv
module peer_bus_model (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_i,
  // scenario choices
  input  wire logic win_i,
  input  wire logic slow_i,
  // requests from the block
  input  wire logic nop_req_i,
  input  wire logic tx_valid_i,
  // answers of the peers
  output logic      bnr_o,
  output logic      won_o,
  output logic      lost_o,
  output logic      tx_ready_o,
  output logic      built_in_self_test_done_o
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [5:0] age_q;  // cycles since reset, saturating
  logic [3:0] arb_q;  // cycles the nop request has waited
  logic       hit;    // arbitration outcome cycle

  // time since reset
  always_ff @(posedge mclk_i)
    if (rst_i)
      age_q <= 6'h00;
    else if (age_q != 6'h3F)
      age_q <= age_q + 6'h01;

  // nop arbitration delay
  always_ff @(posedge mclk_i)
    if (rst_i || !nop_req_i)
      arb_q <= 4'h0;
    else
      arb_q <= arb_q + 4'h1;

  // all peers end self-test together
  assign built_in_self_test_done_o = age_q == (slow_i ? 6'h0A : 6'h03);
  // peers toggle the line, then it goes quiet
  assign bnr_o = (age_q < 6'h14) ? age_q[0] : 1'b1;
  // one outcome pulse; a higher priority peer wins when win_i is low
  assign hit = nop_req_i && arb_q == (slow_i ? 4'h5 : 4'h1);
  assign won_o = hit && win_i;
  assign lost_o = hit && !win_i;
  // when slow, message path stalls on odd ages, and on every cycle once the age saturates at 3F, so a send must hold
  assign tx_ready_o = tx_valid_i && (!slow_i || !age_q[0]);
endmodule : peer_bus_model

// ### tb/boot_election_tb_top.sv
`include "boot_elect_consts.svh"

module boot_election_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // stimulus, quiet at time zero; interrupts off during election
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [31:0] topo_id_i = 32'h0;
  logic        ext_topology_i = 1'b0;
  logic        new_variant_i = 1'b0;
  logic        core_halt_i = 1'b0;
  logic        intr_i = 1'b0;
  logic        nmi_i = 1'b0;
  logic        system_management_interrupt_i = 1'b0;
  logic        snoop_i = 1'b0;
  logic        clock_stop_request_i = 1'b0;
  logic        svr_wr_i = 1'b0;
  logic [31:0] svr_wdata_i = 32'h0;
  logic        win = 1'b0;
  logic        slow = 1'b0;
  boot_elect_pkg::ipi_msg_t msg_rx_i = '0;
  // answers
  logic built_in_self_test_start_o, built_in_self_test_done_i, block_next_request_line_i, nop_req_o, nop_won_i;
  logic nop_lost_i, msg_tx_ready_i, intr_take_o, nmi_take_o, smi_take_o, snoop_take_o;
  logic clock_stop_take_o, boot_processor_o, elect_done_o, ctrl_enable_o;
  logic [31:0] arb_priority_o, processor_identifier_o, mmio_identifier_o;
  boot_elect_pkg::ipi_msg_t     msg_tx_o;
  boot_elect_pkg::fetch_req_t   fetch_o;
  boot_elect_pkg::elect_state_t state_o;
  int miscompares = 0;
  int n_checks = 0;

  boot_election i_dut (.*);
  peer_bus_model i_peers (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .win_i       (win),
    .slow_i      (slow),
    .nop_req_i   (nop_req_o),
    .tx_valid_i  (msg_tx_o.valid),
    .bnr_o       (block_next_request_line_i),
    .won_o       (nop_won_i),
    .lost_o      (nop_lost_i),
    .tx_ready_o  (msg_tx_ready_i),
    .built_in_self_test_done_o (built_in_self_test_done_i)
  );

  // 250 MHz clock
  initial
    forever #2 mclk_i = ~mclk_i;

  // compare and count
  task automatic check(input string w, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask : check

  // bounded wait for a state
  task automatic wait_st(input boot_elect_pkg::elect_state_t s);
    int i;
    i = 0;
    do @(posedge mclk_i) #1; while (state_o !== s && ++i < 100);
    check("state", s, state_o);
  endtask : wait_st

  // hard reset with straps and peer behaviour
  task automatic boot(input logic v, e, input logic [31:0] t, input logic w, s);
    @(posedge mclk_i);
    rst_i <= 1'b1;
    new_variant_i <= v;
    ext_topology_i <= e;
    topo_id_i <= t;
    win <= w;
    slow <= s;
    // every interrupt source quiet for the election
    intr_i <= 1'b0;
    nmi_i <= 1'b0;
    system_management_interrupt_i <= 1'b0;
    snoop_i <= 1'b0;
    clock_stop_request_i <= 1'b0;
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
  endtask : boot

  // one received message pulse
  task automatic send(input boot_elect_pkg::msg_kind_t k, input logic [31:0] s);
    @(posedge mclk_i);
    msg_rx_i <= '{1'b1, k, s, 8'hBD};
    @(posedge mclk_i);
    msg_rx_i <= '0;
    #1;
  endtask : send

  // bus election won, identifier views, enable, soft init
  task automatic t_bus_win;
    boot(1'b1, 1'b1, 32'h1234_56A5, 1'b1, 1'b0);
    wait_st(boot_elect_pkg::ST_SELFTEST);
    check("enable", 32'h0, ctrl_enable_o);
    wait_st(boot_elect_pkg::ST_ARB_NOP);
    check("priority", 32'h1234_56A5, arb_priority_o);
    check("id", 32'h1234_56A5, processor_identifier_o);
    check("mapped id", 32'hA500_0000, mmio_identifier_o);
    wait_st(boot_elect_pkg::ST_RUN_BOOT);
    check("fetch", `RESET_VECTOR, fetch_o.addr);
    check("flag", 32'h1, boot_processor_o);
    @(posedge mclk_i);
    svr_wr_i <= 1'b1;  // boot side enables; error entry sits outside
    svr_wdata_i <= 32'h0000_0100;
    @(posedge mclk_i);
    svr_wr_i <= 1'b0;
    @(posedge mclk_i) #1;
    check("enable", 32'h1, ctrl_enable_o);
    send(boot_elect_pkg::MSG_SOFT_INIT, 32'h0);
    check("soft init", boot_elect_pkg::ST_RUN_BOOT, state_o);
    check("refetch", 32'h1, fetch_o.valid);
  endtask : t_bus_win

  // bus election lost, narrow id, startup page, halted masking
  task automatic t_bus_lose;
    boot(1'b1, 1'b0, 32'h1234_5678, 1'b0, 1'b1);
    wait_st(boot_elect_pkg::ST_WAIT_START);
    check("flag", 32'h0, boot_processor_o);
    check("done", 32'h1, elect_done_o);
    check("narrow id", 32'h78, processor_identifier_o);
    // boot side has set its tally to one before the wake-up
    for (int k = 0; k < 4; k++)
      if (k != 2)
      begin
        send(boot_elect_pkg::msg_kind_t'(k), 32'h0);  // soft init last
        check("ignored", boot_elect_pkg::ST_WAIT_START, state_o);
      end
    // lone secondary finds the semaphore free
    send(boot_elect_pkg::MSG_STARTUP, 32'h0);  // first startup
    check("run", boot_elect_pkg::ST_RUN_SEC, state_o);
    check("page", 32'h000B_D000, fetch_o.addr);
    send(boot_elect_pkg::MSG_STARTUP, 32'h0);  // second startup
    check("second start", boot_elect_pkg::ST_RUN_SEC, state_o);
    check("no refetch", 32'h0, fetch_o.valid);
    @(posedge mclk_i);
    core_halt_i <= 1'b1;  // secondary counted, masked, halts
    intr_i <= 1'b1;
    nmi_i <= 1'b1;
    system_management_interrupt_i <= 1'b1;
    snoop_i <= 1'b1;
    clock_stop_request_i <= 1'b1;
    #1;
    check("intr run", 32'h1, intr_take_o);
    @(posedge mclk_i);
    core_halt_i <= 1'b0;
    #1;
    check("halted", boot_elect_pkg::ST_HALTED, state_o);
    check("intr take", 32'h0, intr_take_o);
    check("nmi take", 32'h1, nmi_take_o);
    check("smi take", 32'h1, smi_take_o);
    check("snoop take", 32'h1, snoop_take_o);
    check("clock stop take", 32'h1, clock_stop_take_o);
    send(boot_elect_pkg::MSG_SOFT_INIT, 32'h0);
    check("init wakes", boot_elect_pkg::ST_WAIT_START, state_o);
  endtask : t_bus_lose

  // message election won
  task automatic t_msg_win;
    boot(1'b0, 1'b1, 32'h3, 1'b1, 1'b0);
    wait_st(boot_elect_pkg::ST_SEND_SEL);
    check("sel kind", boot_elect_pkg::MSG_BOOT_SELECT, msg_tx_o.kind);
    check("sel src", 32'h3, msg_tx_o.src_id);
    send(boot_elect_pkg::MSG_BOOT_SELECT, 32'h3);  // own select back
    check("flag", 32'h1, boot_processor_o);
    check("fin kind", boot_elect_pkg::MSG_FINAL_SELECT, msg_tx_o.kind);
    wait_st(boot_elect_pkg::ST_WAIT_FIN);
    send(boot_elect_pkg::MSG_FINAL_SELECT, 32'h3);
    check("boot", boot_elect_pkg::ST_RUN_BOOT, state_o);
    check("fetch", `RESET_VECTOR, fetch_o.addr);
  endtask : t_msg_win

  // message election lost, final select ignored
  task automatic t_msg_lose;
    boot(1'b0, 1'b1, 32'h5, 1'b0, 1'b1);
    wait_st(boot_elect_pkg::ST_WAIT_SEL);  // held send, then wait
    send(boot_elect_pkg::MSG_BOOT_SELECT, 32'h2);  // peer select first
    check("loser", boot_elect_pkg::ST_WAIT_START, state_o);
    send(boot_elect_pkg::MSG_FINAL_SELECT, 32'h2);
    check("no fetch", 32'h0, fetch_o.valid);
    check("flag", 32'h0, boot_processor_o);
  endtask : t_msg_lose

  // counts and verdict
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  // main sequence
  initial
  begin
    t_bus_win();
    t_bus_lose();
    t_msg_win();
    t_msg_lose();
    conclude();
  end

  // watchdog
  initial
  begin
    #40000;
    miscompares++;
    conclude();
  end
endmodule : boot_election_tb_top
